// ---- design/bcd_chain.sv ----
// Chain of BCD decades for the main counter, with split test grouping.
// Assumes clr and inc are synchronous to clk.
`timescale 1ns/100ps
module bcd_chain #(
    parameter int NDEC = ucc_pkg::DIGITS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic inc,
    input wire logic split,
    output logic [4*NDEC-1:0] value,
    output logic carry
);
    logic [NDEC-1:0] step;
    genvar i;
    generate
        for (i = 0; i < NDEC; i++)
        begin : g_dec
            logic [3:0] dec_r;
            if (i == 0)
                assign step[i] = inc;
            else if (i % 2 == 0)
                assign step[i] = split ? inc : (step[i-1] && value[4*i-1 -: 4] == 4'h9);
            else
                assign step[i] = step[i-1] && value[4*i-1 -: 4] == 4'h9;
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    dec_r <= 4'h0;
                else if (clr)
                    dec_r <= 4'h0;
                else if (step[i])
                    dec_r <= (dec_r == 4'h9) ? 4'h0 : dec_r + 4'h1;
            end
            assign value[4*i+3 -: 4] = dec_r;
        end
    endgenerate
    assign carry = step[NDEC-1] && value[4*NDEC-1 -: 4] == 4'h9;
endmodule

// ---- design/display_scanner.sv ----
// Digit scan timer: on time, blanking gap, digit index.
// Assumes clk at the package rate.
`timescale 1ns/100ps
module display_scanner #(
    parameter int ON_CYC = ucc_pkg::DIGIT_ON_CYC,
    parameter int GAP_CYC = ucc_pkg::GAP_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    scan_if.scanner sif
);
    import ucc_pkg::*;
    localparam int SW = $clog2(ON_CYC + GAP_CYC);
    localparam logic [SW-1:0] LAST = SW'(ON_CYC + GAP_CYC - 1);
    localparam logic [SW-1:0] ON_END = SW'(ON_CYC - 1);
    logic [SW-1:0] slot_r;
    logic [2:0] digit_r;
    wire slot_end = (slot_r == LAST);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            slot_r <= '0;
            digit_r <= '0;
        end
        else
        begin
            slot_r <= slot_end ? '0 : slot_r + 1'b1;
            if (slot_end)
                digit_r <= digit_r + 1'b1;
        end
    end

    assign sif.digit = digit_r;
    assign sif.active = (slot_r <= ON_END);
    // Sampling at the close of the on time lands in the stable half
    assign sif.sample = (slot_r == ON_END);
endmodule

// ---- design/scan_if.sv ----
// Display scan position passed from the scanner to the control logic.
// Assumes both ends share clk.
`timescale 1ns/100ps
interface scan_if;
    logic [2:0] digit;
    logic active;
    logic sample;
    modport scanner (output digit, output active, output sample);
    modport user (input digit, input active, input sample);
endinterface

// ---- design/ucc_pkg.sv ----
// Constants and types shared by the universal counter control block.
// Assumes a single 25 MHz clock; every slower rate is an enable pulse.
package ucc_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int DIGITS = 8;
    localparam int DIGIT_ON_NS = 244000;
    localparam int GAP_NS = 6000;
    localparam int DIGIT_ON_CYC = (DIGIT_ON_NS / 1000) * (CLK_HZ / 1000000);
    localparam int GAP_CYC = (GAP_NS / 1000) * (CLK_HZ / 1000000);
    localparam int REF_HZ = 100;
    localparam int REF_CYC = CLK_HZ / REF_HZ;
    localparam int PAUSE_MS = 200;
    localparam int PAUSE_CYC = (CLK_HZ / 1000) * PAUSE_MS;
    localparam int EXT_MIN_HZ = 100000;
    localparam int EXT_MIN_CYC = CLK_HZ / EXT_MIN_HZ;
    // Digit strobe that selects each option
    localparam int FN_FREQ_DIG = 0;
    localparam int FN_PERIOD_DIG = 7;
    localparam int FN_RATIO_DIG = 1;
    localparam int FN_INTERVAL_DIG = 4;
    localparam int FN_UNIT_DIG = 3;
    localparam int FN_OSC_DIG = 2;
    localparam int RNG_EXT_DIG = 4;
    localparam int CTL_OFF_DIG = 3;
    localparam int CTL_DTEST_DIG = 7;
    localparam int CTL_MHZ1_DIG = 1;
    localparam int CTL_EXTOSC_DIG = 0;
    localparam int CTL_EXTDP_DIG = 2;
    localparam int CTL_TEST_DIG = 4;
    localparam int OVF_DIG = 7;
    localparam logic [10:0] TEST_REF_STEP = 11'h064;
    typedef enum {FN_FREQ, FN_PERIOD, FN_RATIO, FN_INTERVAL, FN_UNIT, FN_OSC} func_t;
    typedef enum {ST_READY, ST_MEAS, ST_PAUSE} meas_state_t;
endpackage

// ---- design/universal_counter_control.sv ----
// Control, measurement and display logic of the universal counter.
// Assumes all pins synchronous to clk; the oscillator is modelled by clk.
// Contract
// - Display test lights all, display off overrides
// - D3 control with hold enters display off
// - 1MHz option keeps rates, shifts period point
// - External oscillator clocks period and interval
// - Slow external oscillator reverts to on-chip
// - External point shown, stops blanking below it
// - Test splits counter, skips reference decades
// - Range or external input ends measurement
// - Range change aborts except unit counter
// - Function routes main and reference inputs
// - A falling sets, B falling clears interval
// - Function change aborts without display update, except into unit counter or in test
// - Overflow lights point during digit seven
// - Hold stops, clears counter, keeps display
// - Unit mode hold freezes count
// - Reset acts as hold, shows zeros
// - BCD digit output unaffected by blanking
// - Scan 500Hz, 244us on, 6us gap
// - No blanking after point or on overflow
// - Point placed for kHz and microseconds
// - Count only falling edges of A, B
// - Fixed 0.2 second pause between measurements
`timescale 1ns/100ps
module universal_counter_control #(
    parameter int DIGIT_ON_CYC_P = ucc_pkg::DIGIT_ON_CYC,
    parameter int REF_CYC_P = ucc_pkg::REF_CYC,
    parameter int PAUSE_CYC_P = ucc_pkg::PAUSE_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic input_a,
    input wire logic input_b,
    input wire logic ext_osc,
    input wire logic function_in,
    input wire logic range_in,
    input wire logic control_in,
    input wire logic ext_dp_in,
    input wire logic ext_range_in,
    input wire logic hold_in,
    input wire logic reset_in,
    output logic [7:0] digit_out,
    output logic digit_oe_n,
    output logic [7:0] seg_out,
    output logic seg_oe_n,
    output logic [3:0] bcd_out,
    output logic meas_busy,
    output logic store_out
);
    import ucc_pkg::*;

    // ****************************************
    // Scan and multiplexed input capture
    // ****************************************
    scan_if sif();
    display_scanner #(.ON_CYC(DIGIT_ON_CYC_P), .GAP_CYC(GAP_CYC)) u_scan (
        .clk(clk),
        .arst_n(arst_n),
        .sif(sif)
    );

    logic [7:0] func_sel_r, range_sel_r, ctrl_sel_r, dp_sel_r;
    logic disp_off_r;
    // Frozen while the display is off, so noise then cannot change modes
    wire take = sif.sample && !disp_off_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            func_sel_r <= 8'h01;
            range_sel_r <= 8'h01;
            ctrl_sel_r <= 8'h00;
            dp_sel_r <= 8'h00;
        end
        else if (take)
        begin
            func_sel_r[sif.digit] <= function_in;
            range_sel_r[sif.digit] <= range_in;
            ctrl_sel_r[sif.digit] <= control_in;
            dp_sel_r[sif.digit] <= ext_dp_in;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            disp_off_r <= 1'b0;
        else if (!hold_in)
            disp_off_r <= 1'b0;
        else if (take && sif.digit == 3'(CTL_OFF_DIG) && control_in)
            disp_off_r <= 1'b1;
    end

    function automatic func_t decode_func(input logic [7:0] s);
        if (s[FN_PERIOD_DIG])
            return FN_PERIOD;
        else if (s[FN_INTERVAL_DIG])
            return FN_INTERVAL;
        else if (s[FN_UNIT_DIG])
            return FN_UNIT;
        else if (s[FN_OSC_DIG])
            return FN_OSC;
        else if (s[FN_RATIO_DIG])
            return FN_RATIO;
        else
            return FN_FREQ;
    endfunction

    // Enum is two-state, so it lives in a variable rather than a net
    func_t func;
    assign func = decode_func(func_sel_r);
    wire unit_mode = (func == FN_UNIT);
    wire ext_rng_en = range_sel_r[RNG_EXT_DIG];
    wire [1:0] rng = range_sel_r[3] ? 2'd3 : range_sel_r[2] ? 2'd2 : range_sel_r[1] ? 2'd1 : 2'd0;
    wire mhz1 = ctrl_sel_r[CTL_MHZ1_DIG];
    wire ext_osc_en = ctrl_sel_r[CTL_EXTOSC_DIG];
    wire ext_dp_en = ctrl_sel_r[CTL_EXTDP_DIG];
    wire test_en = ctrl_sel_r[CTL_TEST_DIG];
    wire disp_test = ctrl_sel_r[CTL_DTEST_DIG];

    // ****************************************
    // Input edges, oscillator choice, interval gate
    // ****************************************
    localparam int AW = $clog2(EXT_MIN_CYC + 1);
    logic a_prev_r, b_prev_r, x_prev_r, rng_prev_r, interval_gate_flop_r;
    logic [AW-1:0] ext_age_r;
    wire a_fall = a_prev_r && !input_a;
    wire b_fall = b_prev_r && !input_b;
    wire x_fall = x_prev_r && !ext_osc;
    wire rng_fall = rng_prev_r && !ext_range_in;
    wire ext_ok = (ext_age_r < AW'(EXT_MIN_CYC));
    wire use_ext = ext_osc_en && ext_ok;
    // With the 1MHz option the rates still come from clk, so scan and pause match
    wire osc_evt = use_ext ? x_fall : 1'b1;
    wire gate_fall = interval_gate_flop_r && b_fall;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
            x_prev_r <= 1'b0;
            rng_prev_r <= 1'b0;
            ext_age_r <= AW'(EXT_MIN_CYC);
            interval_gate_flop_r <= 1'b0;
        end
        else
        begin
            a_prev_r <= input_a;
            b_prev_r <= input_b;
            x_prev_r <= ext_osc;
            rng_prev_r <= ext_range_in;
            if (x_fall)
                ext_age_r <= '0;
            else if (ext_ok)
                ext_age_r <= ext_age_r + 1'b1;
            if (interval_gate_flop_r ? b_fall : a_fall)
                interval_gate_flop_r <= !interval_gate_flop_r;
        end
    end

    // ****************************************
    // Routing and reference counting
    // ****************************************
    localparam int RW = $clog2(REF_CYC_P);
    logic [RW-1:0] ref_div_r;
    wire tick100 = (ref_div_r == RW'(REF_CYC_P - 1));
    logic main_evt, ref_evt;

    always_comb
    begin
        main_evt = 1'b0;
        ref_evt = 1'b0;
        case (func)
            FN_FREQ:
            begin
                main_evt = a_fall;
                ref_evt = tick100;
            end
            FN_PERIOD:
            begin
                main_evt = osc_evt;
                ref_evt = a_fall;
            end
            FN_RATIO:
            begin
                main_evt = a_fall;
                ref_evt = b_fall;
            end
            FN_INTERVAL:
            begin
                main_evt = osc_evt && interval_gate_flop_r;
                ref_evt = gate_fall;
            end
            FN_OSC:
            begin
                main_evt = 1'b1;
                ref_evt = tick100;
            end
            default:
            begin
                main_evt = a_fall;
                ref_evt = 1'b0;
            end
        endcase
    end

    logic [10:0] ref_cnt_r;
    wire [10:0] ref_limit = (rng == 2'd0) ? 11'd1 : (rng == 2'd1) ? 11'd10 : (rng == 2'd2) ? 11'd100 : 11'd1000;
    // Test mode clocks the third decade directly
    wire [10:0] ref_step = test_en ? TEST_REF_STEP : 11'h001;
    wire [10:0] ref_next = ref_cnt_r + ref_step;

    // ****************************************
    // Measurement sequence
    // ****************************************
    localparam int PW = $clog2(PAUSE_CYC_P);
    meas_state_t state_r;
    logic [PW-1:0] pause_cnt_r;
    func_t func_prev_r;
    logic [4:0] rsel_prev_r;
    logic ovf_r;
    wire [4:0] rsel = {2'h0, ext_rng_en, rng};
    wire changed = (func != func_prev_r) || (!unit_mode && rsel != rsel_prev_r);
    wire stop = hold_in || reset_in || disp_off_r;
    wire ref_done = ext_rng_en ? rng_fall : (ref_evt && ref_next >= ref_limit);
    wire end_meas = !unit_mode && !stop && !changed && state_r == ST_MEAS && ref_done;
    wire pause_done = (pause_cnt_r == PW'(PAUSE_CYC_P - 1));
    // Unit mode clears only on reset; hold just freezes it
    wire main_clr = unit_mode ? reset_in : (stop || changed || end_meas);
    wire main_inc = unit_mode ? (!stop && main_evt) : (state_r == ST_MEAS && main_evt);
    wire [31:0] cnt_val;
    wire cnt_carry;

    bcd_chain #(.NDEC(DIGITS)) u_main (
        .clk(clk),
        .arst_n(arst_n),
        .clr(main_clr),
        .inc(main_inc),
        .split(test_en),
        .value(cnt_val),
        .carry(cnt_carry)
    );

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_READY;
            pause_cnt_r <= '0;
            ref_cnt_r <= '0;
            ref_div_r <= '0;
            func_prev_r <= FN_FREQ;
            rsel_prev_r <= '0;
            ovf_r <= 1'b0;
        end
        else
        begin
            func_prev_r <= func;
            rsel_prev_r <= rsel;
            ref_div_r <= tick100 ? '0 : ref_div_r + 1'b1;
            ovf_r <= main_clr ? 1'b0 : (ovf_r || (main_inc && cnt_carry));
            pause_cnt_r <= (state_r == ST_PAUSE) ? pause_cnt_r + 1'b1 : '0;
            if (state_r == ST_MEAS && ref_evt)
                ref_cnt_r <= ref_next;
            if (unit_mode)
                state_r <= ST_MEAS;
            else if (stop)
            begin
                state_r <= ST_READY;
                ref_cnt_r <= '0;
            end
            else if (changed || state_r == ST_READY)
            begin
                state_r <= ST_MEAS;
                ref_cnt_r <= '0;
            end
            else if (end_meas)
                state_r <= ST_PAUSE;
            else if (state_r == ST_PAUSE && pause_done)
            begin
                state_r <= ST_MEAS;
                ref_cnt_r <= '0;
            end
        end
    end

    // ****************************************
    // Display latches
    // ****************************************
    logic [31:0] disp_val_r;
    logic disp_ovf_r, store_r;
    wire latch_cnt = end_meas || (unit_mode && !reset_in) || (test_en && !stop);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            disp_val_r <= '0;
            disp_ovf_r <= 1'b0;
            store_r <= 1'b0;
        end
        else
        begin
            store_r <= end_meas;
            if (reset_in)
            begin
                disp_val_r <= '0;
                disp_ovf_r <= 1'b0;
            end
            else if (latch_cnt)
            begin
                disp_val_r <= cnt_val;
                disp_ovf_r <= ovf_r || (main_inc && cnt_carry);
            end
        end
    end

    // ****************************************
    // Decimal point, blanking, segment drive
    // ****************************************
    function automatic logic [6:0] seg7(input logic [3:0] v);
        case (v)
            4'h0: return 7'h3F;
            4'h1: return 7'h06;
            4'h2: return 7'h5B;
            4'h3: return 7'h4F;
            4'h4: return 7'h66;
            4'h5: return 7'h6D;
            4'h6: return 7'h7D;
            4'h7: return 7'h07;
            4'h8: return 7'h7F;
            4'h9: return 7'h6F;
            default: return 7'h00;
        endcase
    endfunction

    // Frequency in kHz, time in microseconds, ratio per reference count
    wire time_fn = (func == FN_PERIOD || func == FN_INTERVAL);
    wire [2:0] int_dp = time_fn ? 3'(rng) + {2'b00, !mhz1} : (func == FN_RATIO) ? 3'(rng) : 3'(rng) + 3'd1;
    wire int_dp_on = !unit_mode && !(func == FN_RATIO && rng == 2'd0) && !(time_fn && mhz1 && rng == 2'd0);
    wire [2:0] ext_dp = dp_sel_r[6] ? 3'd6 : dp_sel_r[5] ? 3'd5 : dp_sel_r[4] ? 3'd4 : dp_sel_r[3] ? 3'd3 :
        dp_sel_r[2] ? 3'd2 : dp_sel_r[1] ? 3'd1 : 3'd0;
    wire [2:0] keep_pos = ext_dp_en ? ext_dp : (int_dp_on ? int_dp : 3'd0);
    wire [7:0] blank_vec;
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++)
        begin : g_blank
            wire hi_blank;
            if (g == DIGITS - 1)
                assign hi_blank = 1'b1;
            else
                assign hi_blank = blank_vec[g+1];
            assign blank_vec[g] = hi_blank && disp_val_r[4*g+3 -: 4] == 4'h0 && 3'(g) > keep_pos && !disp_ovf_r;
        end
    endgenerate

    wire [2:0] d = sif.digit;
    wire [3:0] nib = disp_val_r[4*d +: 4];
    wire dp_here = (ext_dp_en ? dp_sel_r[d] : (int_dp_on && d == int_dp)) || (d == 3'(OVF_DIG) && disp_ovf_r);
    wire [7:0] seg_nxt = !sif.active ? 8'h00 : disp_test ? 8'hFF : blank_vec[d] ? 8'h00 : {dp_here, seg7(nib)};
    wire [7:0] dig_nxt = sif.active ? 8'(1 << d) : 8'h00;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            digit_out <= 8'h00;
            seg_out <= 8'h00;
            bcd_out <= 4'h0;
            digit_oe_n <= 1'b1;
            seg_oe_n <= 1'b1;
            meas_busy <= 1'b0;
            store_out <= 1'b0;
        end
        else
        begin
            digit_out <= dig_nxt;
            seg_out <= disp_off_r ? 8'h00 : seg_nxt;
            bcd_out <= nib;
            digit_oe_n <= disp_off_r;
            seg_oe_n <= disp_off_r;
            meas_busy <= (state_r == ST_MEAS) && !stop;
            store_out <= store_r;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_off_float;
        @(posedge clk) disable iff (!arst_n) disp_off_r |=> digit_oe_n && seg_oe_n;
    endproperty
    a_off_float: assert property (p_off_float) else $error("drivers not floated in display off");

    property p_test_lit;
        @(posedge clk) disable iff (!arst_n) disp_test && !disp_off_r && sif.active |=> seg_out == 8'hFF;
    endproperty
    a_test_lit: assert property (p_test_lit) else $error("display test not all lit");

    property p_hold_clear;
        @(posedge clk) disable iff (!arst_n) hold_in && !unit_mode |=> cnt_val == 32'h0000_0000 && !meas_busy;
    endproperty
    a_hold_clear: assert property (p_hold_clear) else $error("hold did not clear count");

    property p_unit_freeze;
        @(posedge clk) disable iff (!arst_n)
            (unit_mode && hold_in && !reset_in) ##1 (unit_mode && hold_in && !reset_in) |-> $stable(cnt_val);
    endproperty
    a_unit_freeze: assert property (p_unit_freeze) else $error("unit count moved under hold");

    property p_reset_zero;
        @(posedge clk) disable iff (!arst_n) reset_in |=> disp_val_r == 32'h0000_0000 ##1 bcd_out == 4'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset did not show zeros");

    property p_change_abort;
        @(posedge clk) disable iff (!arst_n)
            func != func_prev_r && !test_en && !reset_in && func != FN_UNIT |=> $stable(disp_val_r) && !store_r;
    endproperty
    a_change_abort: assert property (p_change_abort) else $error("function change updated display");

    property p_ovf_point;
        @(posedge clk) disable iff (!arst_n)
            disp_ovf_r && sif.active && d == 3'(OVF_DIG) && !disp_off_r |=> seg_out[7];
    endproperty
    a_ovf_point: assert property (p_ovf_point) else $error("overflow point missing");

    property p_pause_stay;
        @(posedge clk) disable iff (!arst_n)
            state_r == ST_PAUSE && !pause_done && !stop && !changed && !unit_mode |=> state_r == ST_PAUSE;
    endproperty
    a_pause_stay: assert property (p_pause_stay) else $error("pause ended early");

    property p_gate_set;
        @(posedge clk) disable iff (!arst_n) !interval_gate_flop_r && a_fall |=> interval_gate_flop_r;
    endproperty
    a_gate_set: assert property (p_gate_set) else $error("interval gate not set by A");

    property p_store_latch;
        @(posedge clk) disable iff (!arst_n) end_meas |=> disp_val_r == $past(cnt_val) ##1 store_out;
    endproperty
    a_store_latch: assert property (p_store_latch) else $error("end of measurement not stored");
endmodule

// ---- testbench/panel_wiring.sv ----
// Front panel model: switches tie digit strobes to the multiplexed inputs.
// Assumes digit_out is one-hot and registered on the design clock.
`timescale 1ns/100ps
module panel_wiring (
    input wire logic [7:0] digit_out,
    input wire logic [7:0] fn_mask,
    input wire logic [7:0] rng_mask,
    input wire logic [7:0] ctl_mask,
    input wire logic [7:0] dp_mask,
    output logic function_in,
    output logic range_in,
    output logic control_in,
    output logic ext_dp_in
);
    // ********************
    // Switch contacts
    // ********************
    // Levels follow the strobe, so they hold over the whole digit
    assign function_in = |(digit_out & fn_mask);
    assign range_in = |(digit_out & rng_mask);
    assign control_in = |(digit_out & ctl_mask);
    // Digit seven is never wired here, it would hide overflow
    assign ext_dp_in = |(digit_out & dp_mask & 8'h7F);
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the universal counter control block.
// Assumes shortened scan, reference and pause counts.
`timescale 1ns/100ps
module testbench;
    import ucc_pkg::*;
    localparam int ON_P = 20;
    localparam int PAUSE_P = 30;
    logic clk = 1'b0, arst_n = 1'b0, input_a = 1'b0, input_b = 1'b0, ext_osc = 1'b0;
    logic hold_in = 1'b0, reset_in = 1'b0, ext_range_in = 1'b0;
    logic [7:0] fn_mask = 8'h00, rng_mask = 8'h00, ctl_mask = 8'h00, dp_mask = 8'h00;
    logic function_in, range_in, control_in, ext_dp_in, digit_oe_n, seg_oe_n, meas_busy, store_out;
    logic [7:0] digit_out, seg_out;
    logic [3:0] bcd_out, v;
    int seed = 26851, failures = 0, checks = 0, cycles = 0, n, k;
    universal_counter_control #(.DIGIT_ON_CYC_P(ON_P), .REF_CYC_P(50), .PAUSE_CYC_P(PAUSE_P))
        universal_counter_control_i (.clk(clk), .arst_n(arst_n), .input_a(input_a), .input_b(input_b),
        .ext_osc(ext_osc), .function_in(function_in), .range_in(range_in), .control_in(control_in),
        .ext_dp_in(ext_dp_in), .ext_range_in(ext_range_in), .hold_in(hold_in), .reset_in(reset_in),
        .digit_out(digit_out), .digit_oe_n(digit_oe_n), .seg_out(seg_out), .seg_oe_n(seg_oe_n),
        .bcd_out(bcd_out), .meas_busy(meas_busy), .store_out(store_out));
    panel_wiring panel_wiring_i (.digit_out(digit_out), .fn_mask(fn_mask), .rng_mask(rng_mask),
        .ctl_mask(ctl_mask), .dp_mask(dp_mask), .function_in(function_in), .range_in(range_in),
        .control_in(control_in), .ext_dp_in(ext_dp_in));
    // ********************
    // Helpers
    // ********************
    task automatic wrap_up;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    function automatic logic [3:0] exp_digit(input int val, input int d);
        return 4'((val / (10 ** d)) % 10);
    endfunction
    task automatic wait_digit(input int d);
        int w;
        w = 0;
        while (digit_out !== (8'h01 << d) && w < 2000)
        begin
            @(negedge clk);
            w++;
        end
        check("digit_seen", digit_out, 8'h01 << d);
    endtask
    task automatic pulse_a(input int cnt);
        repeat (cnt)
        begin
            @(posedge clk) input_a <= 1'b1;
            repeat (2) @(posedge clk);
            input_a <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    initial
    begin
        forever #20 clk = ~clk;
    end
    // Free-running far-side traffic on B and the external oscillator
    always @(posedge clk)
    begin
        input_b <= 1'($random(seed));
        ext_osc <= ~ext_osc;
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            wrap_up();
        end
    end
    // ********************
    // Scenarios
    // ********************
    initial
    begin
        repeat (6) @(posedge clk);
        check("rst_digit", digit_out, 8'h00);
        check("rst_oe", {7'h00, digit_oe_n}, 8'h01);
        arst_n <= 1'b1;
        wait_digit(1);
        wait_digit(0);
        for (n = 0; digit_out === 8'h01; n++) @(negedge clk);
        check("on_time", 8'(n), 8'(ON_P));
        for (n = 0; digit_out === 8'h00; n++) @(negedge clk);
        check("gap_time", 8'(n), 8'(GAP_CYC));
        check("next_digit", digit_out, 8'h02);
        for (n = 0; store_out !== 1'b1 && n < 3000; n++) @(negedge clk);
        check("store_seen", {7'h00, store_out}, 8'h01);
        check("meas_busy_end", {7'h00, meas_busy}, 8'h00);
        for (n = 0; meas_busy !== 1'b1 && n < 100; n++) @(negedge clk);
        check("pause", 8'(n >= PAUSE_P - 1 && n <= PAUSE_P + 1), 8'h01);
        fn_mask <= 8'h08;
        @(posedge clk) reset_in <= 1'b1;
        repeat (3000) @(posedge clk);
        reset_in <= 1'b0;
        n = 10 + ({$random(seed)} % 80);
        pulse_a(n);
        hold_in <= 1'b1;
        pulse_a(3);
        hold_in <= 1'b0;
        for (k = 0; k < 2; k++)
        begin
            wait_digit(k);
            v = bcd_out;
            check("unit_digit", 8'(v), 8'(exp_digit(n, k)));
        end
        pulse_a(1);
        wait_digit(0);
        check("resume", 8'(bcd_out), 8'(exp_digit(n + 1, 0)));
        @(posedge clk) reset_in <= 1'b1;
        repeat (4) @(posedge clk);
        reset_in <= 1'b0;
        wait_digit(1);
        check("reset_zero", 8'(bcd_out), 8'h00);
        check("lead_blank", seg_out, 8'h00);
        ctl_mask <= 8'h04;
        dp_mask <= 8'h08;
        repeat (3000) @(posedge clk);
        for (k = 2; k < 5; k++)
        begin
            wait_digit(k);
            check("ext_point", seg_out, (k == 2) ? 8'h3F : (k == 3) ? 8'hBF : 8'h00);
        end
        ctl_mask <= 8'h10;
        dp_mask <= 8'h00;
        repeat (3000) @(posedge clk);
        pulse_a(25);
        wait_digit(6);
        check("split_digit", 8'(bcd_out), 8'h05);
        pulse_a(75);
        wait_digit(7);
        check("ovf_point", seg_out, 8'hBF);
        ctl_mask <= 8'h80;
        repeat (3000) @(posedge clk);
        wait_digit(2);
        check("test_segs", seg_out, 8'hFF);
        @(posedge clk) hold_in <= 1'b1;
        ctl_mask <= 8'h88;
        repeat (3000) @(posedge clk);
        check("off_oe", {6'h00, digit_oe_n, seg_oe_n}, 8'h03);
        hold_in <= 1'b0;
        repeat (10) @(posedge clk);
        check("on_again", {7'h00, digit_oe_n}, 8'h00);
        wrap_up();
    end
endmodule
